// >>> rtl/sa_auth_engine.v
// challenge-response authentication engine with secret store
// Function
// - hash one 512-bit block of secret, challenge and 384 constant bits.
// - address variant puts the 64-bit net address into the constant bits.
// - return the 160-bit code serially, least significant bit first.
// - the secret itself never leaves the device.
// - opcode 0Ch takes 64 challenge bits, first bit right after the opcode.
// - more than 64 challenge bits leave the challenge undefined.
// - opcode 36h hashes with all-ones in the address field, returns code.
// - opcode 35h hashes with the net address, returns code.
// - hash completes within the hash time after the opcode.
// - opcode 5Ah clears the secret to zero in nonvolatile store.
// - opcode 30h stores 64 hash bits, all-ones address, as new secret.
// - opcode 33h stores 64 hash bits, with net address, as new secret.
// - opcode 60h sets the nonvolatile secret lock bit.
// - address is family byte, 48-bit serial, then 8-bit crc.
// - the crc byte is the top byte of the net address.
// - device never checks the address crc nor stops on mismatch.
// - one master; this device only ever answers as a slave.
// - a link reset is answered with a presence pulse.
`timescale 1ns/10ps
`include "sa_auth_defs.vh"

// one armed command per link reset; challenge, gap and send phases
// drop back to idle on a link reset, a hash or a secret write does not.
// secret and lock bit live in flops, so sys_rst stands for a blank part;
// the write time is only a counter in this model.
module sa_auth_engine #(
  parameter [7:0]  FAMILY_CODE = 8'h5e,              // arbitrary value
  parameter [47:0] SERIAL_NUM  = 48'h0123456789ab,   // arbitrary value
  parameter        NVW_CYCLES  = `SA_T_NVW_US * `SA_CLK_MHZ
) (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       lnk_rst,
  input  wire       cmd_valid,
  input  wire [7:0] cmd_code,
  input  wire       wr_valid,
  input  wire       wr_bit,
  input  wire       rd_req,
  output reg        presence,
  output reg        out_bit,
  output reg        out_valid,
  output reg        busy,
  output reg        locked
);

  // crc over the low 56 address bits, lsb first, register cleared to zero
  // folded to a constant at elaboration, so no crc logic is built
  function [7:0] sa_crc56;
    input [55:0] data;
    integer i;
    reg [7:0] c;
    reg       fb;
    begin
      c = 8'h00;
      for (i = 0; i < 56; i = i + 1) begin
        fb = c[0] ^ data[i];
        c  = {1'b0, c[7:1]};
        if (fb) begin
          c = c ^ `SA_CRC_POLY;
        end
      end
      sa_crc56 = c;
    end
  endfunction

  localparam [7:0]  ADDR_CRC = sa_crc56({SERIAL_NUM, FAMILY_CODE});
  localparam [63:0] NET_ADDR = {ADDR_CRC, SERIAL_NUM, FAMILY_CODE};

  // counter runs down to zero inclusive, so it loads one short
  localparam [31:0] NVW_LOAD = NVW_CYCLES - 1;

  // states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CHAL = 3'h1;
  localparam [2:0] ST_HASH = 3'h2;
  localparam [2:0] ST_GAP  = 3'h3;
  localparam [2:0] ST_SEND = 3'h4;
  localparam [2:0] ST_NVW  = 3'h5;

  // what the pending nonvolatile write will do
  localparam [1:0] NV_CLEAR = 2'h0;
  localparam [1:0] NV_NEXT  = 2'h1;
  localparam [1:0] NV_LOCK  = 2'h2;

  // sequencer state and the data it carries between phases
  reg  [2:0]     state;
  reg            armed;
  reg  [63:0]    secret;
  reg  [63:0]    chal;
  reg  [6:0]     chal_cnt;
  reg            use_addr;
  reg            to_secret;
  reg  [1:0]     nv_op;
  reg  [63:0]    nv_data;
  reg  [31:0]    nv_cnt;
  reg  [159:0]   mac;
  reg  [7:0]     slot_cnt;
  reg            hash_go;

  // hash core hand-over and the assembled block
  wire           hash_done;
  wire [159:0]   digest;
  wire [63:0]    addr_field;
  wire [511:0]   block;
  wire           cmd_take;

  // only ever reacts to what the master sends
  // commands are taken only when idle and after a link reset
  assign cmd_take = cmd_valid && armed && (state == ST_IDLE);

  // all-ones address field for the plain variant
  // net address replaces 64 of the constant bits
  assign addr_field = use_addr ? NET_ADDR : `SA_ONES64;

  // secret, challenge, address field, then ten filler words
  assign block = {secret, chal, addr_field,
                  {10{`SA_PAD_WORD}}};

  // one round per clock, so every hash takes the same time
  sa_sha1_core u_core (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (hash_go),
    .block   (block),
    .done    (hash_done),
    .digest  (digest)
  );

  // presence pulse one cycle after each link reset
  // a link reset in the same cycle as a command wins, so the
  // arming is never lost to a racing command
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      presence <= 1'b0;
      armed    <= 1'b0;
    end else begin
      presence <= lnk_rst;
      if (lnk_rst) begin
        armed <= 1'b1;
      end else if (cmd_take) begin
        armed <= 1'b0;
      end
    end
  end

  // address crc is never checked; a bad crc cannot stop anything
  // main sequencer
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      secret    <= 64'h0;
      locked    <= 1'b0;
      chal      <= 64'h0;
      chal_cnt  <= 7'h00;
      use_addr  <= 1'b0;
      to_secret <= 1'b0;
      nv_op     <= NV_CLEAR;
      nv_data   <= 64'h0;
      nv_cnt    <= 32'h0;
      mac       <= 160'h0;
      slot_cnt  <= 8'h00;
      hash_go   <= 1'b0;
      out_bit   <= 1'b0;
      out_valid <= 1'b0;
      busy      <= 1'b0;
    end else begin
      // strobes fall by default and rise for one cycle below
      hash_go   <= 1'b0;
      out_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          // nothing is pending once back in idle
          busy <= 1'b0;
          if (cmd_take) begin
            case (cmd_code)
              // challenge bits may follow on the very next cycle
              `SA_OP_LOAD_CHAL: begin
                chal_cnt <= 7'h00;
                state    <= ST_CHAL;
              end
              `SA_OP_MAC_NOADDR: begin
                use_addr  <= 1'b0;
                to_secret <= 1'b0;
                hash_go   <= 1'b1;
                busy      <= 1'b1;
                state     <= ST_HASH;
              end
              `SA_OP_MAC_ADDR: begin
                use_addr  <= 1'b1;
                to_secret <= 1'b0;
                hash_go   <= 1'b1;
                busy      <= 1'b1;
                state     <= ST_HASH;
              end
              `SA_OP_NEXT_NOADDR: begin
                if (!locked) begin
                  use_addr  <= 1'b0;
                  to_secret <= 1'b1;
                  hash_go   <= 1'b1;
                  busy      <= 1'b1;
                  state     <= ST_HASH;
                end
              end
              `SA_OP_NEXT_ADDR: begin
                if (!locked) begin
                  use_addr  <= 1'b1;
                  to_secret <= 1'b1;
                  hash_go   <= 1'b1;
                  busy      <= 1'b1;
                  state     <= ST_HASH;
                end
              end
              // zero the secret after the write time
              `SA_OP_CLR_SECRET: begin
                if (!locked) begin
                  nv_op   <= NV_CLEAR;
                  nv_data <= 64'h0;
                  nv_cnt  <= NVW_LOAD;
                  busy    <= 1'b1;
                  state   <= ST_NVW;
                end
              end
              // lock bit written through the same timed path
              `SA_OP_LOCK_SECRET: begin
                nv_op  <= NV_LOCK;
                nv_cnt <= NVW_LOAD;
                busy   <= 1'b1;
                state  <= ST_NVW;
              end
              // unknown opcode: ignored, but the arming is spent
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_CHAL: begin
          // lsb arrives first, so shift in from the top
          if (lnk_rst) begin
            state <= ST_IDLE;
          end else if (wr_valid) begin
            // bits past the 64th are dropped; the host must
            // treat such a challenge as undefined anyway
            if (chal_cnt != `SA_CHAL_BITS) begin
              chal     <= {wr_bit, chal[63:1]};
              chal_cnt <= chal_cnt + 7'h01;
            end
          end
        end
        ST_HASH: begin
          // a link reset cannot cut the hash short
          // result ready a fixed 81 cycles after the opcode
          if (hash_done) begin
            if (to_secret) begin
              // low 64 digest bits become the new secret
              nv_op   <= NV_NEXT;
              nv_data <= digest[63:0];
              nv_cnt  <= NVW_LOAD;
              state   <= ST_NVW;
            end else begin
              mac      <= digest;
              slot_cnt <= 8'h00;
              busy     <= 1'b0;
              state    <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // eight written slots are consumed before reading starts
          if (lnk_rst) begin
            // an abandoned code is wiped so no later read can see it
            mac   <= 160'h0;
            state <= ST_IDLE;
          end else if (wr_valid) begin
            if (slot_cnt == `SA_GAP_SLOTS - 8'h01) begin
              slot_cnt <= 8'h00;
              state    <= ST_SEND;
            end else begin
              slot_cnt <= slot_cnt + 8'h01;
            end
          end
        end
        ST_SEND: begin
          // code bits leave least significant first
          // only the digest copy is ever shifted, never the secret
          if (lnk_rst) begin
            mac   <= 160'h0;
            state <= ST_IDLE;
          end else if (rd_req) begin
            out_bit   <= mac[0];
            out_valid <= 1'b1;
            mac       <= {1'b0, mac[159:1]};
            if (slot_cnt == `SA_MAC_SLOTS - 8'h01) begin
              state <= ST_IDLE;
            end else begin
              slot_cnt <= slot_cnt + 8'h01;
            end
          end
        end
        ST_NVW: begin
          // link reset does not cut a secret write short
          if (nv_cnt == 32'h0) begin
            case (nv_op)
              NV_LOCK: begin
                locked <= 1'b1;
              end
              default: begin
                secret <= nv_data;
              end
            endcase
            // no copy of the secret is left in the staging word
            nv_data <= 64'h0;
            busy    <= 1'b0;
            state   <= ST_IDLE;
          end else begin
            nv_cnt <= nv_cnt - 32'h1;
          end
        end
        default: begin
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sa_auth_engine

// >>> rtl/sa_auth_defs.vh
// constants for the challenge-response hash engine
`ifndef SA_AUTH_DEFS_VH
`define SA_AUTH_DEFS_VH

// function opcodes
`define SA_OP_LOAD_CHAL   8'h0c
`define SA_OP_MAC_NOADDR  8'h36
`define SA_OP_MAC_ADDR    8'h35
`define SA_OP_CLR_SECRET  8'h5a
`define SA_OP_NEXT_NOADDR 8'h30
`define SA_OP_NEXT_ADDR   8'h33
`define SA_OP_LOCK_SECRET 8'h60

// field widths and counts
`define SA_KEY_W      64
`define SA_MAC_W      160
`define SA_GAP_SLOTS  8'h08
`define SA_MAC_SLOTS  8'ha0
`define SA_CHAL_BITS  7'h40

// address layout: family, serial, crc (crc in top byte)
`define SA_FAM_LSB    0
`define SA_SER_LSB    8
`define SA_CRC_LSB    56
`define SA_CRC_POLY   8'h8c

// fixed filler words of the hashed block
`define SA_PAD_WORD   32'h00000000
`define SA_ONES64     64'hffffffffffffffff

// hash initial values and round constants
`define SA_H0 32'h67452301
`define SA_H1 32'hefcdab89
`define SA_H2 32'h98badcfe
`define SA_H3 32'h10325476
`define SA_H4 32'hc3d2e1f0
`define SA_K0 32'h5a827999
`define SA_K1 32'h6ed9eba1
`define SA_K2 32'h8f1bbcdc
`define SA_K3 32'hca62c1d6
`define SA_LAST_ROUND 7'h4f

// timing: nonvolatile write time in us, clock in MHz
`define SA_T_NVW_US   2000
`define SA_CLK_MHZ    100

`endif

// >>> rtl/sa_sha1_core.v
// one-block sha-1 engine, one round per clock
`timescale 1ns/10ps
`include "sa_auth_defs.vh"

module sa_sha1_core (
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         start,
  input  wire [511:0] block,
  output reg          done,
  output reg  [159:0] digest
);

  reg  [31:0] wa, wb, wc, wd, we;
  reg  [31:0] w [0:15];
  reg  [6:0]  rnd;
  reg         run;
  reg  [31:0] f;
  reg  [31:0] k;
  wire [31:0] w_new;
  wire [31:0] temp;

  // message schedule as a sliding 16-word window
  assign w_new = {w[13][30:0] ^ w[8][30:0] ^ w[2][30:0] ^ w[0][30:0],
                  w[13][31] ^ w[8][31] ^ w[2][31] ^ w[0][31]};
  assign temp  = {wa[26:0], wa[31:27]} + f + we + k + w[0];

  // round function picked by round number
  always @* begin
    if (rnd < 7'd20) begin
      f = (wb & wc) | (~wb & wd);
      k = `SA_K0;
    end else if (rnd < 7'd40) begin
      f = wb ^ wc ^ wd;
      k = `SA_K1;
    end else if (rnd < 7'd60) begin
      f = (wb & wc) | (wb & wd) | (wc & wd);
      k = `SA_K2;
    end else begin
      f = wb ^ wc ^ wd;
      k = `SA_K3;
    end
  end

  // window load on start, shift while running
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_win
      always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          w[gi] <= 32'h00000000;
        end else if (start && !run) begin
          w[gi] <= block[511-32*gi -: 32];
        end else if (run) begin
          if (gi == 15) begin
            w[gi] <= w_new;
          end else begin
            w[gi] <= w[(gi+1) % 16];
          end
        end
      end
    end
  endgenerate

  // working variables and final addition
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wa     <= 32'h00000000;
      wb     <= 32'h00000000;
      wc     <= 32'h00000000;
      wd     <= 32'h00000000;
      we     <= 32'h00000000;
      rnd    <= 7'h00;
      run    <= 1'b0;
      done   <= 1'b0;
      digest <= 160'h0;
    end else begin
      done <= 1'b0;
      if (start && !run) begin
        wa  <= `SA_H0;
        wb  <= `SA_H1;
        wc  <= `SA_H2;
        wd  <= `SA_H3;
        we  <= `SA_H4;
        rnd <= 7'h00;
        run <= 1'b1;
      end else if (run) begin
        wa  <= temp;
        wb  <= wa;
        wc  <= {wb[1:0], wb[31:2]};
        wd  <= wc;
        we  <= wd;
        rnd <= rnd + 7'h01;
        // last round folds in the chaining values directly
        if (rnd == `SA_LAST_ROUND) begin
          run    <= 1'b0;
          done   <= 1'b1;
          digest <= {temp + `SA_H0, wa + `SA_H1,
                     {wb[1:0], wb[31:2]} + `SA_H2,
                     wc + `SA_H3, wd + `SA_H4};
        end
      end
    end
  end

endmodule // sa_sha1_core

// >>> verification/sa_auth_checker.sv
// port checker for the authentication engine
`timescale 1ns/10ps
module sa_auth_checker #(
  parameter NVW_CYCLES = 20
) (
  input wire       clk_sys,
  input wire       sys_rst,
  input wire       lnk_rst,
  input wire       cmd_valid,
  input wire [7:0] cmd_code,
  input wire       wr_valid,
  input wire       wr_bit,
  input wire       rd_req,
  input wire       presence,
  input wire       out_bit,
  input wire       out_valid,
  input wire       busy,
  input wire       locked
);
  // longest busy: hash plus nonvolatile write, with margin
  localparam int BUSY_MAX = NVW_CYCLES + 120;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // presence answers only a link reset
  chk_presence_answer: assert property (lnk_rst |=> presence)
    else $error("no presence after link reset");
  chk_presence_cause: assert property (presence |-> $past(lnk_rst))
    else $error("presence without link reset");
  // code bits only follow a read slot
  chk_out_cause: assert property (out_valid |-> $past(rd_req))
    else $error("code bit without read slot");
  chk_out_quiet: assert property (busy |-> !out_valid)
    else $error("code bit while busy");
  // busy starts from an accepted command and ends in time
  chk_busy_cause: assert property ($rose(busy) |-> $past(cmd_valid))
    else $error("busy without command");
  chk_busy_min: assert property ($rose(busy) |-> busy [*8])
    else $error("busy too short");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("busy never ends");
  // lock never falls back
  chk_lock_sticky: assert property (locked |=> locked)
    else $error("lock bit cleared");
  chk_lock_write: assert property ($rose(locked) |-> $fell(busy))
    else $error("lock set outside a write");
  // code bit holds between read slots
  chk_bit_hold: assert property (!out_valid |-> $stable(out_bit))
    else $error("code bit moved without read slot");

  cover property (lnk_rst ##1 presence);
  cover property ($fell(busy));
  cover property ($rose(locked));
endmodule // sa_auth_checker

// >>> verification/sa_host_model.sv
// bus master model driving link reset, opcodes and bit slots
`timescale 1ns/10ps
module sa_host_model (
  input wire       clk_sys,
  input wire       presence,
  input wire       out_bit,
  input wire       out_valid,
  output reg       lnk_rst,
  output reg       cmd_valid,
  output reg [7:0] cmd_code,
  output reg       wr_valid,
  output reg       wr_bit,
  output reg       rd_req
);
  // idle strobes at time zero
  initial begin
    lnk_rst = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    wr_valid = 1'b0;
    wr_bit = 1'b0;
    rd_req = 1'b0;
  end

  // master opens each transaction with a reset
  task lrst(output reg p);
    @(posedge clk_sys);
    lnk_rst <= 1'b1;
    @(posedge clk_sys);
    lnk_rst <= 1'b0;
    #1 p = presence;
  endtask

  // argument bits follow the opcode back to back, lsb first
  task cmd(input [7:0] code, input [63:0] arg, input reg with_arg);
    integer i;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code <= ~code; // stale opcode never looks valid
    if (with_arg) begin
      for (i = 0; i < 64; i = i + 1) begin
        wr_valid <= 1'b1;
        wr_bit <= arg[i];
        @(posedge clk_sys);
      end
      wr_valid <= 1'b0;
      wr_bit <= ~wr_bit;
    end
  endtask

  // eight zero slots, then 160 read slots
  task get_mac(output [159:0] m, output reg ok);
    integer i;
    ok = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk_sys);
      wr_valid <= 1'b1;
      wr_bit <= 1'b0;
    end
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    wr_bit <= 1'b1;
    for (i = 0; i < 160; i = i + 1) begin
      @(posedge clk_sys);
      rd_req <= 1'b1;
      @(posedge clk_sys);
      rd_req <= 1'b0;
      #1 ok = ok & (out_valid === 1'b1);
      m[i] = out_bit;
    end
  endtask
endmodule // sa_host_model

// >>> verification/tb_sha1_auth_secret_engine.sv
// self-checking bench for the authentication engine
`timescale 1ns/10ps
`include "sa_auth_defs.vh"
`define CHK(g, e) begin cmp_count = cmp_count + 1; \
  if ((g) !== (e)) begin fails = fails + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_sha1_auth_secret_engine;
  localparam [7:0]  FAM = 8'h2d;           // arbitrary value
  localparam [47:0] SER = 48'h3c5a96e1f00d; // arbitrary value
  localparam        NVW = 20;
  reg          clk_sys;
  reg          sys_rst;
  wire         lnk_rst, cmd_valid, wr_valid, wr_bit, rd_req;
  wire [7:0]   cmd_code;
  wire         presence, out_bit, out_valid, busy, locked;
  integer      fails, cmp_count, seed, i;
  reg [63:0]   sec, chal, net;
  reg          lk, p, ok;
  reg [159:0]  d, m;
  reg [7:0]    ops [0:14];

  // free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  sa_auth_engine #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .NVW_CYCLES(NVW))
  dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk_rst(lnk_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
    .wr_bit(wr_bit), .rd_req(rd_req), .presence(presence),
    .out_bit(out_bit), .out_valid(out_valid), .busy(busy),
    .locked(locked));

  sa_host_model host (.clk_sys(clk_sys), .presence(presence),
    .out_bit(out_bit), .out_valid(out_valid), .lnk_rst(lnk_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
    .wr_bit(wr_bit), .rd_req(rd_req));

  // reference hash of one raw block, word 0 in the top bits
  function automatic [159:0] sha1(input [511:0] b);
    reg [31:0] w [0:79];
    reg [31:0] a, bb, c, dd, e, f, k, t;
    integer j;
    for (j = 0; j < 80; j = j + 1) begin
      if (j < 16) w[j] = b[511-32*j -: 32];
      else begin
        t = w[j-3] ^ w[j-8] ^ w[j-14] ^ w[j-16];
        w[j] = {t[30:0], t[31]};
      end
    end
    {a, bb, c, dd, e} = {`SA_H0, `SA_H1, `SA_H2, `SA_H3, `SA_H4};
    for (j = 0; j < 80; j = j + 1) begin
      if (j < 20) {f, k} = {(bb & c) | (~bb & dd), `SA_K0};
      else if (j < 40) {f, k} = {bb ^ c ^ dd, `SA_K1};
      else if (j < 60) {f, k} = {(bb & c) | (bb & dd) | (c & dd), `SA_K2};
      else {f, k} = {bb ^ c ^ dd, `SA_K3};
      t = {a[26:0], a[31:27]} + f + e + k + w[j];
      {a, bb, c, dd, e} = {t, a, bb[1:0], bb[31:2], c, dd};
    end
    sha1 = {a + `SA_H0, bb + `SA_H1, c + `SA_H2, dd + `SA_H3, e + `SA_H4};
  endfunction

  // address crc, cleared, fed lsb first
  function automatic [7:0] crc8(input [55:0] v);
    integer j;
    crc8 = 8'h00;
    for (j = 0; j < 56; j = j + 1)
      crc8 = (crc8 >> 1) ^ ((crc8[0] ^ v[j]) ? 8'h8c : 8'h00);
  endfunction

  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for the engine to go idle
  task wait_idle;
    integer j;
    j = 0;
    @(posedge clk_sys);
    #1;
    while (busy !== 1'b0 && j < 2000) begin
      @(posedge clk_sys);
      #1 j = j + 1;
    end
    if (j >= 2000) begin
      fails = fails + 1;
      conclude;
    end
  endtask

  // one command with fresh challenge, expected secret tracked here
  task run(input [7:0] op);
    reg hsh, adr;
    hsh = (op == 8'h35 || op == 8'h36 || op == 8'h30 || op == 8'h33);
    adr = (op == 8'h35 || op == 8'h33);
    chal = {$random(seed), $random(seed)};
    host.lrst(p);
    `CHK(p, 1'b1)
    if (hsh) begin
      host.cmd(8'h0c, chal, 1'b1);
      host.lrst(p);
    end
    host.cmd(op, 64'h0, 1'b0);
    d = sha1({sec, chal, adr ? net : {64{1'b1}}, 320'h0});
    wait_idle;
    if (op == 8'h35 || op == 8'h36) begin
      host.get_mac(m, ok);
      `CHK(ok, 1'b1)
      `CHK(m, d)
    end
    if (!lk && hsh && !(op == 8'h35 || op == 8'h36)) sec = d[63:0];
    if (!lk && op == 8'h5a) sec = 64'h0;
    if (op == 8'h60) lk = 1'b1;
    `CHK(locked, lk)
    $display("test op %h done", op);
  endtask

  // main sequence: reset, command table, unarmed attempt, verdict
  initial begin
    fails = 0;
    cmp_count = 0;
    seed = 32'h303615bf;
    sec = 64'h0;
    lk = 1'b0;
    // family low, serial, crc in top byte
    net = {crc8({SER, FAM}), SER, FAM};
    ops = '{8'h36, 8'h35, 8'h30, 8'h36, 8'h33, 8'h35, 8'h5a, 8'h36,
      8'h60, 8'h5a, 8'h30, 8'h33, 8'h60, 8'h36, 8'h35};
    sys_rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    `CHK({presence, out_valid, busy, locked}, 4'h0)
    for (i = 0; i < 15; i = i + 1) begin
      if (i == 8) begin
        // unknown opcode spends the arming; the lock below is refused
        host.lrst(p);
        host.cmd(8'ha5, 64'h0, 1'b0);
        host.cmd(8'h60, 64'h0, 1'b0);
        wait_idle;
        `CHK({busy, locked}, 2'b00)
      end
      run(ops[i]);
    end
    conclude;
  end
endmodule // tb_sha1_auth_secret_engine

bind sa_auth_engine sa_auth_checker #(.NVW_CYCLES(NVW_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .lnk_rst(lnk_rst),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
  .wr_bit(wr_bit), .rd_req(rd_req), .presence(presence),
  .out_bit(out_bit), .out_valid(out_valid), .busy(busy),
  .locked(locked));
